// *** abw_pkg.sv ***
// Package of constants for the address break watch unit.
package abw_pkg;
    // Bit numbering follows the 36-bit word convention: bit 0 is the MSB, bit 35 the LSB.
    localparam int WORD_W = 36;
    localparam int ADDR_W = 23;
    // Vector index of documented bit n is (35 - n).
    localparam int FETCH_EN_BIT = 35 - 9;
    localparam int READ_EN_BIT = 35 - 10;
    localparam int WRITE_EN_BIT = 35 - 11;
    localparam int USER_EN_BIT = 35 - 12;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_MSB = 35 - 13;
    localparam int SECTION_LSB = 35 - 17;
    localparam int PC_INHIBIT_BIT = 35 - 8;
    localparam logic [22:0] ADDR_RESET = 23'h00_0000;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    localparam int ENABLE_W = 4;
    localparam int SHADOW_DEPTH = 4;

    // Type of the reference presented with a memory request.
    typedef enum logic [1:0] {
        ABW_REF_NONE,
        ABW_REF_FETCH,
        ABW_REF_READ,
        ABW_REF_WRITE
    } abw_ref_e;
endpackage

// *** abw_setup_store.sv ***
// Small register store holding the break setup words.
`timescale 1ns/10ps
`default_nettype none
module abw_setup_store (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic writeEn,
    input wire logic [1:0] writeIdx,
    input wire logic [26:0] writeData,
    input wire logic [1:0] readIdx,
    output logic [26:0] readData
);
    typedef struct packed {
        logic [abw_pkg::SHADOW_DEPTH-1:0][26:0] mem;
        logic [26:0] rd;
    } abw_store_s;

    abw_store_s state_q;
    abw_store_s state_d;

    always_comb begin
        state_d = state_q;
        if (writeEn) begin
            state_d.mem[writeIdx] = writeData;
        end
        // Read data is registered, so a write shows one cycle after it lands.
        state_d.rd = state_q.mem[readIdx];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign readData = state_q.rd;
endmodule
`default_nettype wire

// *** abw_address_break.sv ***
// Address break comparator and break inhibit flags of the execution unit.
//
// Contract
// - Setup word bits 09, 10, 11 enable fetch, read and write breaks.
// - Setup word bit 12 selects user-mode rather than executive-mode references.
// - Break address register holds setup bits 13-35: section and page/line.
// - A match needs reference address bits 13-35 equal to stored break address.
// - Write qualifier of the reference must equal the stored write compare enable; the code checks it only on a write, and fetch or read uses its own enable.
// - User qualifier must equal the stored user compare setting.
// - Match with both flags clear raises break condition and page illegal entry.
// - Loading flags from a PC word with bit 8 set sets the inhibit flag.
// - Dispatch copies inhibit into suppress-cycle and clears inhibit together.
// - Suppress-cycle set blocks all break conditions for the next instruction.
// - The following dispatch clears suppress-cycle, re-enabling breaks.
// - Instruction abort breaks recirculation and moves suppress-cycle into inhibit.
// - The inhibit flag is readable as a processor flag for saving.
// - The jump-restore-flags flag load sets inhibit when the PC word asks.
// - Jump-clear-flags reads flags, clears selected ones, reloads via flag load.
`timescale 1ns/10ps
`default_nettype none
module abw_address_break (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic processorDataOut,
    input wire logic [35:0] setupWord,
    input wire logic memRequest,
    input wire logic [1:0] referenceType,
    input wire logic [22:0] referenceAddr,
    input wire logic referenceIsUser,
    input wire logic nextInstructionDispatch,
    input wire logic instructionAbort,
    input wire logic loadProcessorFlags,
    input wire logic pcWordInhibit,
    input wire logic jumpClearFlags,
    input wire logic clearInhibitSelect,
    input wire logic pageFailHold,
    output logic addressBreakCondition,
    output logic pageIllegalEntry,
    output logic breakInhibitFlag,
    output logic breakSuppressCycle,
    output logic [35:0] setupReadback,
    output logic breakPending
);
    typedef struct packed {
        logic [22:0] breakAddr;
        logic fetchEn;
        logic readEn;
        logic writeEn;
        logic userComp;
        logic inhibit;
        logic suppress;
        logic pending;
    } abw_state_s;

    abw_state_s state_q;
    abw_state_s state_d;
    logic addrMatch;
    logic typeMatch;
    logic rawMatch;
    logic breakFire;
    logic flagTrapCirculate;
    logic [26:0] storeData;
    logic [26:0] storeRead;

    // Decodes whether a reference type is armed by the current enables.
    function automatic logic typeArmed(input logic [1:0] rt, input logic fe, input logic re,
                                       input logic we);
        typeArmed = ((rt == 2'(abw_pkg::ABW_REF_FETCH)) && fe)
                 || ((rt == 2'(abw_pkg::ABW_REF_READ)) && re)
                 || ((rt == 2'(abw_pkg::ABW_REF_WRITE)) && we);
    endfunction

    assign addrMatch = (referenceAddr == state_q.breakAddr);
    // The write qualifier equals the write enable only on an armed write; a fetch or
    // read is gated by its own enable instead of the write compare.
    assign typeMatch = typeArmed(referenceType, state_q.fetchEn, state_q.readEn,
                                 state_q.writeEn);
    assign rawMatch = memRequest && addrMatch && typeMatch
                   && (referenceIsUser == state_q.userComp);
    assign breakFire = rawMatch && !state_q.inhibit && !state_q.suppress;
    assign flagTrapCirculate = instructionAbort;

    always_comb begin
        state_d = state_q;
        if (processorDataOut) begin
            state_d.fetchEn = setupWord[abw_pkg::FETCH_EN_BIT];
            state_d.readEn = setupWord[abw_pkg::READ_EN_BIT];
            state_d.writeEn = setupWord[abw_pkg::WRITE_EN_BIT];
            state_d.userComp = setupWord[abw_pkg::USER_EN_BIT];
            state_d.breakAddr = setupWord[abw_pkg::ADDR_MSB:abw_pkg::ADDR_LSB];
        end
        // Abort wins over dispatch and flag load: the faulting instruction's flags
        // must be captured before anything else moves them.
        if (flagTrapCirculate) begin
            state_d.inhibit = state_q.suppress;
            state_d.suppress = 1'b0;
        end else if (nextInstructionDispatch) begin
            state_d.suppress = state_q.inhibit;
            state_d.inhibit = 1'b0;
        end else if (loadProcessorFlags) begin
            if (jumpClearFlags) begin
                state_d.inhibit = state_q.inhibit && !clearInhibitSelect;
            end else begin
                state_d.inhibit = pcWordInhibit;
            end
        end
        // Pending stays up from the break request until the memory unit holds.
        if (breakFire) begin
            state_d.pending = 1'b1;
        end else if (pageFailHold) begin
            state_d.pending = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign storeData = {state_q.fetchEn, state_q.readEn, state_q.writeEn, state_q.userComp,
                        state_q.breakAddr};

    // Shadow copy kept so the setup can be read back from a register.
    abw_setup_store abw_setup_store_inst (
        .clock(clock),
        .rst_n(rst_n),
        .writeEn(1'b1),
        .writeIdx(2'h0),
        .writeData(storeData),
        .readIdx(2'h0),
        .readData(storeRead)
    );

    assign setupReadback = {9'h000, storeRead};
    assign addressBreakCondition = breakFire;
    assign pageIllegalEntry = breakFire;
    assign breakInhibitFlag = state_q.inhibit;
    assign breakSuppressCycle = state_q.suppress;
    assign breakPending = state_q.pending;

    sequence SEQ_DISPATCH_WITH_INH;
        nextInstructionDispatch && !instructionAbort && state_q.inhibit;
    endsequence

    // Helper sequences for the checks below; each names one step of a behaviour.
    // A reference that hits the stored address and mode on an armed type.
    sequence SEQ_ARMED_MATCH;
        memRequest && addrMatch && typeMatch && (referenceIsUser == state_q.userComp);
    endsequence

    // A plain flag load with nothing of higher priority in the same cycle.
    sequence SEQ_PLAIN_LOAD;
        loadProcessorFlags && !jumpClearFlags && !instructionAbort && !nextInstructionDispatch;
    endsequence

    // A clear-flags reload with nothing of higher priority in the same cycle.
    sequence SEQ_CLEAR_LOAD;
        loadProcessorFlags && jumpClearFlags && !instructionAbort && !nextInstructionDispatch;
    endsequence

    // No strobe that moves the flags is present.
    sequence SEQ_FLAGS_IDLE;
        !instructionAbort && !nextInstructionDispatch && !loadProcessorFlags;
    endsequence

    // A setup load followed by two quiet cycles, the time the shadow copy needs.
    sequence SEQ_SETUP_SETTLE;
        processorDataOut ##1 !processorDataOut ##1 !processorDataOut;
    endsequence

    // The memory unit holds while no new break is being raised.
    sequence SEQ_HOLD_ALONE;
        pageFailHold && !addressBreakCondition;
    endsequence

    // Suppress-cycle blocks every break for the instruction after the dispatch.
    AST_NO_BREAK_WHEN_SUPPRESSED: assert property (@(posedge clock) disable iff (!rst_n)
        breakSuppressCycle |-> !addressBreakCondition)
        else $error("Break raised while suppress cycle set.");

    // The inhibit flag blocks breaks on its own as well.
    AST_NO_BREAK_WHEN_INHIBITED: assert property (@(posedge clock) disable iff (!rst_n)
        breakInhibitFlag |-> !addressBreakCondition)
        else $error("Break raised while inhibit set.");

    // A hit is blocked by either flag and otherwise always raises the break.
    AST_MATCH_GATED_BY_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
        SEQ_ARMED_MATCH
        |-> addressBreakCondition == (!breakInhibitFlag && !breakSuppressCycle))
        else $error("Matching reference not gated by the flags.");

    // A dispatch hands a set inhibit over to the suppress-cycle flag.
    AST_DISPATCH_MOVES_INH: assert property (@(posedge clock) disable iff (!rst_n)
        SEQ_DISPATCH_WITH_INH |=> breakSuppressCycle && !breakInhibitFlag)
        else $error("Dispatch did not move inhibit into suppress.");

    // A dispatch with inhibit clear re-opens breaks.
    AST_DISPATCH_CLEARS_CYC: assert property (@(posedge clock) disable iff (!rst_n)
        (nextInstructionDispatch && !instructionAbort && !breakInhibitFlag)
        |=> !breakSuppressCycle)
        else $error("Dispatch did not clear suppress cycle.");

    // Nothing but the three strobes may move the flags.
    AST_FLAGS_STEADY: assert property (@(posedge clock) disable iff (!rst_n)
        SEQ_FLAGS_IDLE |=> $stable(breakInhibitFlag) && $stable(breakSuppressCycle))
        else $error("Flags moved without a strobe.");

    // Abort carries the suppress-cycle state back so it can be saved.
    AST_ABORT_RESTORES: assert property (@(posedge clock) disable iff (!rst_n)
        instructionAbort |=> breakInhibitFlag == $past(breakSuppressCycle))
        else $error("Abort did not restore inhibit.");

    // Abort breaks the recirculation, so suppress-cycle does not survive it.
    AST_ABORT_CLEARS_CYC: assert property (@(posedge clock) disable iff (!rst_n)
        instructionAbort |=> !breakSuppressCycle)
        else $error("Abort left suppress cycle set.");

    // A flag load from a word with the inhibit bit set arms the inhibit.
    AST_LOAD_SETS_INH: assert property (@(posedge clock) disable iff (!rst_n)
        (loadProcessorFlags && !jumpClearFlags && pcWordInhibit && !instructionAbort
         && !nextInstructionDispatch) |=> breakInhibitFlag)
        else $error("Flag load did not set inhibit.");

    // A plain load copies the word bit, so a load can also clear the flag.
    AST_PLAIN_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
        SEQ_PLAIN_LOAD |=> breakInhibitFlag == $past(pcWordInhibit))
        else $error("Flag load did not copy the word bit.");

    // The clear-flags reload keeps inhibit unless it was selected for clearing.
    AST_CLEAR_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
        SEQ_CLEAR_LOAD
        |=> breakInhibitFlag == ($past(breakInhibitFlag) && !$past(clearInhibitSelect)))
        else $error("Clear-flags reload gave the wrong inhibit.");

    // The memory unit needs both request qualifiers together.
    AST_BREAK_PAIR: assert property (@(posedge clock) disable iff (!rst_n)
        addressBreakCondition == pageIllegalEntry)
        else $error("Break condition and illegal entry differ.");

    // A break only ever comes with a request on the stored address.
    AST_BREAK_NEEDS_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
        addressBreakCondition |-> memRequest && referenceAddr == state_q.breakAddr)
        else $error("Break without address match.");

    // A break only ever comes with the stored reference mode.
    AST_BREAK_USER: assert property (@(posedge clock) disable iff (!rst_n)
        addressBreakCondition |-> referenceIsUser == state_q.userComp)
        else $error("Break with wrong mode.");

    // A break only ever comes on a reference type whose enable is set.
    AST_BREAK_ARMED_TYPE: assert property (@(posedge clock) disable iff (!rst_n)
        addressBreakCondition
        |-> ((referenceType == 2'(abw_pkg::ABW_REF_FETCH)) && state_q.fetchEn)
        || ((referenceType == 2'(abw_pkg::ABW_REF_READ)) && state_q.readEn)
        || ((referenceType == 2'(abw_pkg::ABW_REF_WRITE)) && state_q.writeEn))
        else $error("Break on a reference type that is not enabled.");

    // A write break needs the write qualifier to meet the write compare enable.
    AST_WRITE_QUALIFIER: assert property (@(posedge clock) disable iff (!rst_n)
        (addressBreakCondition && referenceType == 2'(abw_pkg::ABW_REF_WRITE))
        |-> state_q.writeEn)
        else $error("Write break without write compare enable.");

    // A raised break shows as pending in the next cycle.
    AST_PENDING_SET: assert property (@(posedge clock) disable iff (!rst_n)
        addressBreakCondition |=> breakPending)
        else $error("Break did not set pending.");

    // The hold from the memory unit releases the pending break.
    AST_PENDING_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
        SEQ_HOLD_ALONE |=> !breakPending)
        else $error("Hold did not clear pending.");

    // A setup load takes the write enable and the address.
    AST_SETUP_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
        processorDataOut |=> state_q.writeEn == $past(setupWord[abw_pkg::WRITE_EN_BIT])
        && state_q.breakAddr == $past(setupWord[22:0]))
        else $error("Setup word not loaded.");

    // A setup load takes the other enables and the mode select.
    AST_SETUP_FIELDS: assert property (@(posedge clock) disable iff (!rst_n)
        processorDataOut
        |=> state_q.fetchEn == $past(setupWord[abw_pkg::FETCH_EN_BIT])
        && state_q.readEn == $past(setupWord[abw_pkg::READ_EN_BIT])
        && state_q.userComp == $past(setupWord[abw_pkg::USER_EN_BIT]))
        else $error("Setup enables not loaded.");

    // The break address moves only on a setup load.
    AST_SETUP_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
        !processorDataOut |=> $stable(state_q.breakAddr) && $stable(state_q.writeEn))
        else $error("Setup changed without a load.");

    // The shadow copy shows the loaded setup once it has settled.
    AST_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
        SEQ_SETUP_SETTLE |=> setupReadback[26:0] == $past(setupWord[26:0], 3)
        && setupReadback[35:27] == 9'h000)
        else $error("Setup readback does not match the load.");

    // Reset leaves both flags and the write enable clear.
    AST_RESET_CLEAR: assert property (@(posedge clock)
        !rst_n |=> !breakInhibitFlag && !breakSuppressCycle && !state_q.writeEn)
        else $error("Reset did not clear flags.");

    // Reset leaves the other enables and the pending break clear.
    AST_RESET_CLEARS_ENABLES: assert property (@(posedge clock)
        !rst_n |=> !state_q.fetchEn && !state_q.readEn && !state_q.userComp
        && !breakPending)
        else $error("Reset did not clear enables.");
endmodule
`default_nettype wire

// *** abw_mem_model.sv ***
// Memory unit model that answers address break requests with a page-fail hold.
`timescale 1ns/10ps
`default_nettype none
module abw_mem_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic memRequest,
    input wire logic addressBreakCondition,
    input wire logic pageIllegalEntry,
    output logic pageFailHold
);
    logic [1:0] hold_q;
    // The slow path answers one cycle later, as a busy memory unit would.
    always_ff @(posedge clock) begin
        if (!rst_n) hold_q <= 2'h0;
        else hold_q <= {hold_q[0], memRequest && addressBreakCondition && pageIllegalEntry};
    end
    assign pageFailHold = slow ? hold_q[1] : hold_q[0];
endmodule
`default_nettype wire

// *** abw_address_break_test.sv ***
// Self-checking testbench for the address break watch unit.
`timescale 1ns/10ps
`default_nettype none
module abw_address_break_test;
    logic clock, rst_n, dOut, memReq, user, nid, abort, loadFl, pcInh, jcf, clrSel, slow;
    logic [35:0] setupWord;
    logic [1:0] refType;
    logic [22:0] refAddr;
    wire logic brk, ill, inh, sup, pend, hold;
    wire logic [35:0] rb;
    int n_mismatch = 0;
    int comparisons = 0;
    localparam logic [22:0] ADDR_A = 23'h05_02C0;
    localparam logic [22:0] ADDR_B = 23'h7F_FFFF;
    abw_address_break abw_address_break_inst (.clock(clock), .rst_n(rst_n),
        .processorDataOut(dOut), .setupWord(setupWord), .memRequest(memReq),
        .referenceType(refType), .referenceAddr(refAddr), .referenceIsUser(user),
        .nextInstructionDispatch(nid), .instructionAbort(abort), .loadProcessorFlags(loadFl),
        .pcWordInhibit(pcInh), .jumpClearFlags(jcf), .clearInhibitSelect(clrSel),
        .pageFailHold(hold), .addressBreakCondition(brk), .pageIllegalEntry(ill),
        .breakInhibitFlag(inh), .breakSuppressCycle(sup), .setupReadback(rb),
        .breakPending(pend));
    abw_mem_model abw_mem_model_inst (.clock(clock), .rst_n(rst_n), .slow(slow),
        .memRequest(memReq), .addressBreakCondition(brk), .pageIllegalEntry(ill),
        .pageFailHold(hold));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input string what, input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [35:0] mk(input logic f, r, w, u, input logic [22:0] a);
        return {9'h000, f, r, w, u, a};
    endfunction
    task automatic setup(input logic [35:0] w);
        @(posedge clock);
        dOut <= 1'b1;
        setupWord <= w;
        @(posedge clock);
        dOut <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("readback", rb, {9'h000, w[26:0]});
    endtask
    // One request held for one cycle; break outputs are judged in that cycle.
    task automatic probe(input logic [1:0] t, input logic [22:0] a, input logic u, input logic e);
        @(posedge clock);
        memReq <= 1'b1;
        refType <= t;
        refAddr <= a;
        user <= u;
        #1 chk("break", brk, e);
        chk("illegal entry", ill, e);
        @(posedge clock);
        memReq <= 1'b0;
        #1;
    endtask
    task automatic fl(input logic d, a, l, p, j, c);
        @(posedge clock);
        {nid, abort, loadFl, pcInh, jcf, clrSel} <= {d, a, l, p, j, c};
        @(posedge clock);
        {nid, abort, loadFl, jcf, clrSel} <= 5'h00;
        #1;
    endtask
    task automatic wait_clear();
        int i;
        chk("pending", pend, 1'b1);
        for (i = 0; i < 8 && pend !== 1'b0; i++) begin
            @(posedge clock);
            #1;
        end
        if (pend !== 1'b0) begin
            chk("pending timeout", pend, 1'b0);
            stop_test();
        end
    endtask
    task automatic t_reset();
        chk("inhibit", inh, 1'b0);
        chk("suppress", sup, 1'b0);
        probe(2'h3, 23'h00_0000, 1'b0, 1'b0);
    endtask
    task automatic t_write();
        setup(mk(1'b0, 1'b0, 1'b1, 1'b1, ADDR_A));
        probe(2'h3, ADDR_A, 1'b1, 1'b1);
        wait_clear();
        probe(2'h3, ADDR_A ^ 23'h00_0001, 1'b1, 1'b0);
        probe(2'h3, ADDR_A ^ 23'h40_0000, 1'b1, 1'b0);
        probe(2'h3, ADDR_A, 1'b0, 1'b0);
        probe(2'h2, ADDR_A, 1'b1, 1'b0);
    endtask
    task automatic t_fetch();
        slow <= 1'b1;
        setup(mk(1'b1, 1'b1, 1'b0, 1'b0, ADDR_B));
        probe(2'h1, ADDR_B, 1'b0, 1'b1);
        wait_clear();
        probe(2'h2, ADDR_B, 1'b0, 1'b1);
        probe(2'h3, ADDR_B, 1'b0, 1'b0);
        probe(2'h1, ADDR_B, 1'b1, 1'b0);
        probe(2'h0, ADDR_B, 1'b0, 1'b0);
    endtask
    task automatic t_inhibit();
        fl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("inhibit", inh, 1'b1);
        probe(2'h1, ADDR_B, 1'b0, 1'b0);
        fl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("suppress", {inh, sup}, 2'h1);
        probe(2'h2, ADDR_B, 1'b0, 1'b0);
        fl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("suppress clear", sup, 1'b0);
        probe(2'h2, ADDR_B, 1'b0, 1'b1);
        wait_clear();
    endtask
    task automatic t_abort();
        fl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        fl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        fl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("abort flags", {inh, sup}, 2'h2);
        fl(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        chk("jump clear keep", inh, 1'b1);
        fl(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        chk("jump clear", inh, 1'b0);
        fl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("load with inhibit", inh, 1'b1);
        fl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("load without inhibit", inh, 1'b0);
    endtask
    initial begin
        {rst_n, dOut, memReq, user, nid, abort, loadFl, pcInh, jcf, clrSel, slow} = 11'h000;
        setupWord = 36'h0_0000_0000;
        refType = 2'h0;
        refAddr = 23'h00_0000;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_write();
        t_fetch();
        t_inhibit();
        t_abort();
        stop_test();
    end
endmodule
`default_nettype wire
